// ### core/tam_alert_ctl.sv
// Sleep, single conversion and threshold alert control of the temperature sensor.
//
// Summary of operation
// - Writing sleep_select to 1 stops conversions at once.
// - While asleep the register port still reads every register and writes the configuration and limit registers.
// - Writing sleep_select back to 0 resumes periodic conversions.
// - alert_mode_select picks comparator (0) or interrupt (1) alert behaviour.
// - Comparator: alert asserts after N conversions at or above upper_limit.
// - Comparator: alert releases after N conversions at or below lower_limit.
// - Interrupt: alert asserts after N conversions at or above upper_limit.
// - Interrupt: a completed register read releases the alert.
// - Interrupt: writing sleep_select to 1 also releases the alert.
// - Interrupt: next assert needs below lower_limit, then alternates thresholds.
// - General call reset clears alert_mode_select, back to comparator.
// - threshold_flag shows the same level as the alert pin.
// - alert_sense_level 0 means active low, 1 means active high.
// - fault_count_select codes 0..3 need 1..4 consecutive faults.
// - While asleep, one_shot_trigger starts one conversion and reads 1 meanwhile.
// - On completion the device sleeps again and one_shot_trigger clears.
// - Limit registers move most significant byte first, both directions.
// - Limits use the temperature_value format and compare directly.
// - Power-up limits: lower 0x4b0, upper 0x500.
// - Configuration register is 16 bits, most significant byte first.
`timescale 1ns/1ps
module tam_alert_ctl #(
	parameter int CONV_PERIOD_CYC = tam_pkg::CONV_PERIOD_CYC,
	parameter int TMR_W = 27
) (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic [1:0] reg_index_i,
	input wire logic xfer_start_i,
	input wire logic wr_byte_i,
	input wire logic [7:0] wr_data_i,
	input wire logic rd_byte_i,
	output logic [7:0] rd_data_o,
	input wire logic gc_reset_i,
	input wire logic conv_done_i,
	input wire logic [15:0] conv_value_i,
	output logic conv_run_o,
	output logic asleep_o,
	output logic alert_o
);

	if (CONV_PERIOD_CYC < 1 || CONV_PERIOD_CYC >= (2 ** (TMR_W - 1)))
	begin : g_bad_period
		$error("tam_alert_ctl: CONV_PERIOD_CYC does not fit the timer");
	end

	localparam logic [TMR_W-1:0] TMR_LOAD = TMR_W'(CONV_PERIOD_CYC - 1);

	// ==========================================================
	// Storage.
	logic [15:0] temp_value;
	logic [15:0] upper_limit;
	logic [15:0] lower_limit;
	logic [1:0] conv_rate;
	logic rsv4;
	logic sleep_select;
	logic alert_mode_select;
	logic alert_sense_level;
	logic [1:0] fault_count_select;
	logic one_shot_trigger;
	logic [7:0] hold_msb;
	logic ptr;
	logic active;
	logic phase_low;
	logic [TMR_W-1:0] tmr;
	tam_pkg::tam_state_e state;
	tam_pkg::tam_state_e next_state;

	// ==========================================================
	// Decoded strobes.
	logic commit;
	logic [15:0] wr_word;
	logic cfg_commit;
	logic rd_done;
	logic sleep_set;
	logic mode_chg;
	logic conv_ok;
	logic in_conv;
	logic target_low;
	logic cond;
	logic sleep_now;

	tam_flt_if flt_bus ();

	// Configuration word as the host sees it.
	function automatic logic [15:0] cfg_word();
		logic [15:0] w;
		w = 16'h0000;
		w[tam_pkg::CFG_RSV4] = rsv4;
		w[tam_pkg::CFG_FLAG] = alert_o;
		w[tam_pkg::CFG_CR_HI:tam_pkg::CFG_CR_LO] = conv_rate;
		w[tam_pkg::CFG_SLEEP] = sleep_select;
		w[tam_pkg::CFG_MODE] = alert_mode_select;
		w[tam_pkg::CFG_SENSE] = alert_sense_level;
		w[tam_pkg::CFG_CF_HI:tam_pkg::CFG_CF_LO] = fault_count_select;
		w[tam_pkg::CFG_RO14] = tam_pkg::RO14_VAL;
		w[tam_pkg::CFG_SHOT] = one_shot_trigger;
		return w;
	endfunction : cfg_word

	// Word behind a register index.
	function automatic logic [15:0] reg_word(input logic [1:0] idx);
		logic [15:0] w;
		w = 16'h0000;
		if (idx == tam_pkg::IDX_TEMP)
			w = temp_value;
		else if (idx == tam_pkg::IDX_CFG)
			w = cfg_word();
		else if (idx == tam_pkg::IDX_LOWER)
			w = lower_limit;
		else
			w = upper_limit;
		return w;
	endfunction : reg_word

	// A write lands on the second byte, so a word never changes half way.
	assign wr_word = {hold_msb, wr_data_i};
	assign commit = wr_byte_i && (ptr == tam_pkg::PTR_LSB);
	assign cfg_commit = commit && (reg_index_i == tam_pkg::IDX_CFG);
	assign rd_done = rd_byte_i && (ptr == tam_pkg::PTR_LSB);
	assign sleep_set = cfg_commit && wr_word[tam_pkg::CFG_SLEEP] && !sleep_select;
	assign mode_chg = (cfg_commit && (wr_word[tam_pkg::CFG_MODE] != alert_mode_select))
		|| (gc_reset_i && alert_mode_select);
	assign in_conv = (state == tam_pkg::ST_CONVERT) || (state == tam_pkg::ST_SHOT);
	assign conv_ok = conv_done_i && in_conv;
	// Sleep as it will stand after this edge, so the engine stops on the write itself.
	assign sleep_now = cfg_commit ? wr_word[tam_pkg::CFG_SLEEP] : sleep_select;

	// ==========================================================
	// Byte pointer: a transfer restarts at the most significant byte.
	always_ff @(posedge clk_i)
	begin
		if (!nrst_i)
			ptr <= tam_pkg::PTR_MSB;
		else if (xfer_start_i)
			ptr <= tam_pkg::PTR_MSB;
		else if (wr_byte_i || rd_byte_i)
			ptr <= ~ptr;
	end

	// Most significant byte is held until its partner arrives.
	always_ff @(posedge clk_i)
	begin
		if (!nrst_i)
			hold_msb <= 8'h00;
		else if (wr_byte_i && (ptr == tam_pkg::PTR_MSB))
			hold_msb <= wr_data_i;
	end

	// Read data, served even while asleep.
	always_ff @(posedge clk_i)
	begin
		if (!nrst_i)
			rd_data_o <= 8'h00;
		else if (rd_byte_i && (ptr == tam_pkg::PTR_MSB))
			rd_data_o <= reg_word(reg_index_i)[15:8];
		else if (rd_byte_i)
			rd_data_o <= reg_word(reg_index_i)[7:0];
	end

	// ==========================================================
	// Limit registers, same signed format as the result.
	always_ff @(posedge clk_i)
	begin
		if (!nrst_i)
		begin
			lower_limit <= tam_pkg::LOWER_RST;
			upper_limit <= tam_pkg::UPPER_RST;
		end
		else if (commit && (reg_index_i == tam_pkg::IDX_LOWER))
			lower_limit <= wr_word;
		else if (commit && (reg_index_i == tam_pkg::IDX_UPPER))
			upper_limit <= wr_word;
	end

	// Result register, loaded only by a conversion that was asked for.
	always_ff @(posedge clk_i)
	begin
		if (!nrst_i)
			temp_value <= 16'h0000;
		else if (conv_ok)
			temp_value <= conv_value_i;
	end

	// ==========================================================
	// Configuration fields.
	always_ff @(posedge clk_i)
	begin
		if (!nrst_i)
		begin
			conv_rate <= tam_pkg::CR_RST;
			rsv4 <= 1'b0;
			sleep_select <= 1'b0;
			alert_sense_level <= 1'b0;
			fault_count_select <= 2'h0;
		end
		else if (cfg_commit)
		begin
			conv_rate <= wr_word[tam_pkg::CFG_CR_HI:tam_pkg::CFG_CR_LO];
			rsv4 <= wr_word[tam_pkg::CFG_RSV4];
			sleep_select <= wr_word[tam_pkg::CFG_SLEEP];
			alert_sense_level <= wr_word[tam_pkg::CFG_SENSE];
			fault_count_select <= wr_word[tam_pkg::CFG_CF_HI:tam_pkg::CFG_CF_LO];
		end
	end

	// Mode bit; the general call reset wins over a write in the same cycle.
	always_ff @(posedge clk_i)
	begin
		if (!nrst_i)
			alert_mode_select <= 1'b0;
		else if (gc_reset_i)
			alert_mode_select <= 1'b0;
		else if (cfg_commit)
			alert_mode_select <= wr_word[tam_pkg::CFG_MODE];
	end

	// Single shot request: a new request beats the completion clear.
	always_ff @(posedge clk_i)
	begin
		if (!nrst_i)
			one_shot_trigger <= 1'b0;
		else if (cfg_commit && wr_word[tam_pkg::CFG_SHOT] && wr_word[tam_pkg::CFG_SLEEP])
			one_shot_trigger <= 1'b1;
		else if ((state == tam_pkg::ST_SHOT) && conv_done_i)
			one_shot_trigger <= 1'b0;
	end

	// ==========================================================
	// Operating state machine.
	always_comb
	begin
		next_state = state;
		case (state)
			tam_pkg::ST_CONVERT:
				if (sleep_now)
					next_state = tam_pkg::ST_SLEEP;
				else if (conv_done_i)
					next_state = tam_pkg::ST_STANDBY;
			tam_pkg::ST_STANDBY:
				if (sleep_now)
					next_state = tam_pkg::ST_SLEEP;
				else if (tmr == '0)
					next_state = tam_pkg::ST_CONVERT;
			tam_pkg::ST_SLEEP:
				if (!sleep_now)
					next_state = tam_pkg::ST_CONVERT;
				else if (one_shot_trigger)
					next_state = tam_pkg::ST_SHOT;
			tam_pkg::ST_SHOT:
				if (conv_done_i)
					next_state = sleep_now ? tam_pkg::ST_SLEEP : tam_pkg::ST_STANDBY;
			default:
				next_state = tam_pkg::ST_SLEEP;
		endcase
	end

	// Power-up begins with a conversion straight away.
	always_ff @(posedge clk_i)
	begin
		if (!nrst_i)
			state <= tam_pkg::ST_CONVERT;
		else
			state <= next_state;
	end

	// Period timer runs from the start of each continuous conversion.
	always_ff @(posedge clk_i)
	begin
		if (!nrst_i)
			tmr <= TMR_LOAD;
		else if ((next_state == tam_pkg::ST_CONVERT) && (state != tam_pkg::ST_CONVERT))
			tmr <= TMR_LOAD;
		else if (tmr != '0)
			tmr <= tmr - 1'b1;
	end

	// Engine and power outputs follow the next state, so sleep acts at once.
	always_ff @(posedge clk_i)
	begin
		if (!nrst_i)
		begin
			conv_run_o <= 1'b1;
			asleep_o <= 1'b0;
		end
		else
		begin
			conv_run_o <= (next_state == tam_pkg::ST_CONVERT) || (next_state == tam_pkg::ST_SHOT);
			asleep_o <= (next_state == tam_pkg::ST_SLEEP);
		end
	end

	// ==========================================================
	// Fault test against the threshold now being watched.
	assign target_low = alert_mode_select ? phase_low : active;
	always_comb
	begin
		if (!target_low)
			cond = $signed(conv_value_i) >= $signed(upper_limit);
		else if (alert_mode_select)
			cond = $signed(conv_value_i) < $signed(lower_limit);
		else
			cond = $signed(conv_value_i) <= $signed(lower_limit);
	end

	assign flt_bus.evt = conv_ok;
	assign flt_bus.cond = cond;
	assign flt_bus.clr = mode_chg;
	assign flt_bus.sel = fault_count_select;

	tam_fault_filter #(
		.CNT_W(2)
	) u_filter (
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.flt(flt_bus.flt)
	);

	// Logical alert state; a new hit beats a release in the same cycle.
	always_ff @(posedge clk_i)
	begin
		if (!nrst_i)
			active <= 1'b0;
		else if (mode_chg)
			active <= 1'b0;
		else if (flt_bus.hit && !alert_mode_select)
			active <= ~active;
		else if (flt_bus.hit)
			active <= 1'b1;
		else if (alert_mode_select && (rd_done || sleep_set))
			active <= 1'b0;
	end

	// Interrupt behaviour alternates between the two thresholds.
	always_ff @(posedge clk_i)
	begin
		if (!nrst_i)
			phase_low <= 1'b0;
		else if (mode_chg)
			phase_low <= 1'b0;
		else if (flt_bus.hit && alert_mode_select)
			phase_low <= ~phase_low;
	end

	// Pin level; idle level is the inverse of the selected active level.
	always_ff @(posedge clk_i)
	begin
		if (!nrst_i)
			alert_o <= 1'b1;
		else
			alert_o <= alert_sense_level ? active : ~active;
	end

	// ==========================================================
	// Checks.
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!nrst_i);

	sleep_stops_a: assert property ($rose(sleep_select) |-> !conv_run_o && asleep_o)
		else $error("conversion kept running after sleep write");
	sleep_write_a: assert property ((sleep_select && commit && reg_index_i == tam_pkg::IDX_LOWER)
		|=> lower_limit == $past(wr_word))
		else $error("limit write lost while asleep");
	wake_resume_a: assert property (($fell(sleep_select) && $past(state) == tam_pkg::ST_SLEEP)
		|-> conv_run_o && state == tam_pkg::ST_CONVERT)
		else $error("no conversion after wake");
	comp_set_a: assert property ((!alert_mode_select && !mode_chg && flt_bus.hit && !active)
		|=> active)
		else $error("comparator alert not asserted");
	comp_release_a: assert property ((!alert_mode_select && !mode_chg && flt_bus.hit && active)
		|=> !active ##1 alert_o == !alert_sense_level)
		else $error("comparator alert not released");
	intr_set_a: assert property ((alert_mode_select && !mode_chg && flt_bus.hit)
		|=> active ##1 alert_o == alert_sense_level)
		else $error("interrupt alert not asserted");
	read_clears_a: assert property ((alert_mode_select && !mode_chg && rd_done && !flt_bus.hit)
		|=> !active)
		else $error("read did not release alert");
	sleep_clears_a: assert property ((alert_mode_select && sleep_set && !flt_bus.hit
		&& !mode_chg) |=> !active)
		else $error("sleep did not release alert");
	phase_flip_a: assert property ((alert_mode_select && !mode_chg && flt_bus.hit)
		|=> phase_low != $past(phase_low))
		else $error("threshold phase did not alternate");
	gc_mode_a: assert property (gc_reset_i
		|=> !alert_mode_select && (!active || !$past(alert_mode_select)))
		else $error("general call reset left interrupt mode");
	flag_read_a: assert property ((rd_byte_i && ptr == tam_pkg::PTR_LSB
		&& reg_index_i == tam_pkg::IDX_CFG) |=> rd_data_o[tam_pkg::CFG_FLAG] == $past(alert_o))
		else $error("flag differs from pin");
	pin_level_a: assert property ($changed(active) && $stable(alert_sense_level)
		|=> alert_o == (alert_sense_level ~^ $past(active)))
		else $error("pin level ignores polarity");
	shot_start_a: assert property ((state == tam_pkg::ST_SLEEP && sleep_select && one_shot_trigger)
		|=> conv_run_o && one_shot_trigger)
		else $error("single conversion not started");
	shot_done_a: assert property ((state == tam_pkg::ST_SHOT && conv_done_i && sleep_select
		&& !cfg_commit) |=> !one_shot_trigger ##1 !conv_run_o)
		else $error("single conversion did not end");
	msb_first_a: assert property ((rd_byte_i && ptr == tam_pkg::PTR_MSB && !xfer_start_i
		&& reg_index_i == tam_pkg::IDX_UPPER) |=> rd_data_o == $past(upper_limit[15:8]))
		else $error("first read byte is not the high byte");

endmodule : tam_alert_ctl

// ### core/tam_fault_filter.sv
// Consecutive fault counter that fires once a streak reaches its length.
`timescale 1ns/1ps
module tam_fault_filter #(
	parameter int CNT_W = 2
) (
	input wire logic clk_i,
	input wire logic nrst_i,
	tam_flt_if.flt flt
);

	if (CNT_W < 2)
	begin : g_bad_width
		$error("tam_fault_filter: CNT_W must hold the code range");
	end

	logic [CNT_W-1:0] cnt;
	logic at_len;

	// The streak is long enough when it already holds the selected code count.
	assign at_len = (cnt == CNT_W'(flt.sel));

	// ==========================================================
	// Streak counter, advanced only by completed conversions.
	always_ff @(posedge clk_i)
	begin
		if (!nrst_i)
			cnt <= '0;
		else if (flt.clr)
			cnt <= '0;
		else if (flt.evt)
		begin
			if (!flt.cond || at_len)
				cnt <= '0;
			else
				cnt <= cnt + 1'b1;
		end
	end

	// Hit pulse one cycle after the conversion that completes the streak.
	always_ff @(posedge clk_i)
	begin
		if (!nrst_i)
			flt.hit <= 1'b0;
		else
			flt.hit <= !flt.clr && flt.evt && flt.cond && at_len;
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!nrst_i);

	streak_reset_a: assert property ((flt.evt && !flt.cond) |=> cnt == '0)
		else $error("streak not restarted");
	hit_length_a: assert property ((flt.evt && flt.cond && !flt.clr && at_len) |=> flt.hit)
		else $error("streak of selected length gave no hit");

endmodule : tam_fault_filter

// ### shared/tam_flt_if.sv
// Interface between the alert control and the consecutive fault filter.
`timescale 1ns/1ps
interface tam_flt_if;
	logic evt;
	logic cond;
	logic clr;
	logic [1:0] sel;
	logic hit;
	modport ctl (output evt, output cond, output clr, output sel, input hit);
	modport flt (input evt, input cond, input clr, input sel, output hit);
endinterface : tam_flt_if

// ### shared/tam_pkg.sv
// Constants and types shared by the temperature alert and mode control logic.
package tam_pkg;

	// ==========================================================
	// Register indices.
	localparam logic [1:0] IDX_TEMP = 2'h0;
	localparam logic [1:0] IDX_CFG = 2'h1;
	localparam logic [1:0] IDX_LOWER = 2'h2;
	localparam logic [1:0] IDX_UPPER = 2'h3;

	// ==========================================================
	// Configuration bit positions.
	localparam int CFG_RSV4 = 4;
	localparam int CFG_FLAG = 5;
	localparam int CFG_CR_LO = 6;
	localparam int CFG_CR_HI = 7;
	localparam int CFG_SLEEP = 8;
	localparam int CFG_MODE = 9;
	localparam int CFG_SENSE = 10;
	localparam int CFG_CF_LO = 11;
	localparam int CFG_CF_HI = 12;
	localparam int CFG_RO14 = 14;
	localparam int CFG_SHOT = 15;

	// ==========================================================
	// Reset values.
	localparam logic [1:0] CR_RST = 2'h2;
	localparam logic RO14_VAL = 1'b1;
	localparam logic [15:0] LOWER_RST = 16'h04b0;
	localparam logic [15:0] UPPER_RST = 16'h0500;

	// ==========================================================
	// Byte pointer: the most significant byte travels first.
	localparam logic PTR_MSB = 1'b0;
	localparam logic PTR_LSB = 1'b1;

	// ==========================================================
	// Timing: conversion period in ms and clock period in ns.
	localparam int CONV_PERIOD_MS = 250;
	localparam int CLK_PERIOD_NS = 4;
	localparam int CONV_PERIOD_CYC = (CONV_PERIOD_MS * 1000000) / CLK_PERIOD_NS;

	// ==========================================================
	// Operating states.
	typedef enum logic [1:0] {ST_CONVERT, ST_STANDBY, ST_SLEEP, ST_SHOT} tam_state_e;

endpackage : tam_pkg

// ### tb/tam_conv_model.sv
// Behavioural model of the converter that sits behind conv_run_o and conv_done_i.
`timescale 1ns/1ps
module tam_conv_model #(
	parameter int DLY = 20
) (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic conv_run_i,
	input wire logic [15:0] temp_i,
	output logic conv_done_o,
	output logic [15:0] conv_value_o
);
	int cnt = 0;

	// ==========================================================
	// Conversion timing
	// One done pulse per run phase, on the falling edge DLY + 1 edges after the run request rises.
	always @(negedge clk_i)
	begin
		if (!nrst_i || !conv_run_i || conv_done_o)
		begin
			cnt <= 0;
			conv_done_o <= 1'b0;
		end
		else if (cnt == DLY)
		begin
			conv_done_o <= 1'b1;
		end
		else
		begin
			cnt <= cnt + 1;
		end
	end

	// The result bus shows garbage outside the done cycle, so a late sample is caught.
	assign conv_value_o = conv_done_o ? temp_i : ~temp_i;

	initial conv_done_o = 1'b0;
endmodule : tam_conv_model

// ### tb/tb_tam_alert_ctl.sv
// Self-checking testbench of the temperature alert and mode control block.
`timescale 1ns/1ps
module tb_tam_alert_ctl;
	logic clk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic [1:0] reg_index_i = 2'h0;
	logic xfer_start_i = 1'b0;
	logic wr_byte_i = 1'b0;
	logic [7:0] wr_data_i = 8'h00;
	logic rd_byte_i = 1'b0;
	logic gc_reset_i = 1'b0;
	logic [7:0] rd_data_o;
	logic conv_done_i;
	logic [15:0] conv_value_i;
	logic conv_run_o;
	logic asleep_o;
	logic alert_o;
	logic [15:0] temp = 16'h0000;
	logic [15:0] v;
	int bad_count = 0;
	int n_tests = 0;
	int n_conv = 0;
	int n0 = 0;
	int cyc = 0;

	// ==========================================================
	// Instances
	tam_alert_ctl #(.CONV_PERIOD_CYC(200), .TMR_W(27)) dut (.clk_i(clk_i), .nrst_i(nrst_i),
		.reg_index_i(reg_index_i), .xfer_start_i(xfer_start_i), .wr_byte_i(wr_byte_i),
		.wr_data_i(wr_data_i), .rd_byte_i(rd_byte_i), .rd_data_o(rd_data_o),
		.gc_reset_i(gc_reset_i), .conv_done_i(conv_done_i), .conv_value_i(conv_value_i),
		.conv_run_o(conv_run_o), .asleep_o(asleep_o), .alert_o(alert_o));
	tam_conv_model #(.DLY(20)) conv (.clk_i(clk_i), .nrst_i(nrst_i), .conv_run_i(conv_run_o),
		.temp_i(temp), .conv_done_o(conv_done_i), .conv_value_o(conv_value_i));

	// ==========================================================
	// Clock, conversion counter and hang guard
	initial forever #2 clk_i = ~clk_i;

	// Only accepted conversions count; the ceiling is well above the planned run.
	always @(posedge clk_i)
	begin
		cyc <= cyc + 1;
		if (conv_done_i && conv_run_o)
			n_conv <= n_conv + 1;
		if (cyc == 30000)
		begin
			bad_count = bad_count + 1;
			test_done();
		end
	end

	// ==========================================================
	// Tasks
	task automatic wreg(input logic [1:0] idx, input logic [15:0] val);
		@(negedge clk_i) xfer_start_i = 1'b1;
		@(negedge clk_i) xfer_start_i = 1'b0;
		reg_index_i = idx;
		wr_byte_i = 1'b1;
		wr_data_i = val[15:8];
		@(negedge clk_i) wr_data_i = val[7:0];
		@(negedge clk_i) wr_byte_i = 1'b0;
	endtask : wreg

	task automatic rreg(input logic [1:0] idx, output logic [15:0] val);
		@(negedge clk_i) xfer_start_i = 1'b1;
		@(negedge clk_i) xfer_start_i = 1'b0;
		reg_index_i = idx;
		rd_byte_i = 1'b1;
		@(negedge clk_i) val[15:8] = rd_data_o;
		@(negedge clk_i) rd_byte_i = 1'b0;
		val[7:0] = rd_data_o;
	endtask : rreg

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests = n_tests + 1;
		if (got !== exp)
		begin
			$display("Error at %0t: got %h expected %h", $time, got, exp);
			bad_count = bad_count + 1;
		end
	endtask : chk

	// Waits for n accepted conversions, then lets the alert pipeline settle.
	task automatic wait_conv(input int n);
		repeat (n) @(posedge clk_i iff (conv_done_i && conv_run_o));
		repeat (4) @(negedge clk_i);
	endtask : wait_conv

	task automatic test_done();
		$display("Checks %0d, mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : test_done

	// ==========================================================
	// Main sequence
	initial
	begin
		repeat (20) @(negedge clk_i);
		nrst_i = 1'b1;
		rreg(2'h1, v);
		chk(v, 16'h40a0);
		rreg(2'h2, v);
		chk(v, 16'h04b0);
		rreg(2'h3, v);
		chk(v, 16'h0500);
		chk(16'(alert_o), 16'h0001);
		wreg(2'h2, 16'h0100);
		wreg(2'h3, 16'h0200);
		wreg(2'h0, 16'h1234);
		rreg(2'h3, v);
		chk(v, 16'h0200);
		rreg(2'h0, v);
		chk(v, 16'h0000);
		// Comparator with every fault count code.
		for (int c = 0; c < 4; c++)
		begin
			wreg(2'h1, 16'h0080 | 16'(c << 11));
			temp = 16'h0300;
			if (c > 0)
			begin
				wait_conv(c);
				chk(16'(alert_o), 16'h0001);
			end
			wait_conv(1);
			chk(16'(alert_o), 16'h0000);
			rreg(2'h1, v);
			chk(16'(v[5]), 16'h0000);
			temp = 16'h0100;
			if (c > 0)
			begin
				wait_conv(c);
				chk(16'(alert_o), 16'h0000);
			end
			wait_conv(1);
			chk(16'(alert_o), 16'h0001);
		end
		// Active-high sense.
		wreg(2'h1, 16'h0480);
		repeat (2) @(negedge clk_i);
		chk(16'(alert_o), 16'h0000);
		temp = 16'h0300;
		wait_conv(1);
		chk(16'(alert_o), 16'h0001);
		wreg(2'h1, 16'h0080);
		temp = 16'h0100;
		wait_conv(1);
		chk(16'(alert_o), 16'h0001);
		// Interrupt behaviour.
		wreg(2'h1, 16'h0280);
		temp = 16'h0300;
		wait_conv(1);
		chk(16'(alert_o), 16'h0000);
		wait_conv(1);
		chk(16'(alert_o), 16'h0000);
		rreg(2'h0, v);
		repeat (2) @(negedge clk_i);
		chk(16'(alert_o), 16'h0001);
		wait_conv(1);
		chk(16'(alert_o), 16'h0001);
		temp = 16'h0050;
		wait_conv(1);
		chk(16'(alert_o), 16'h0000);
		rreg(2'h2, v);
		repeat (2) @(negedge clk_i);
		chk(16'(alert_o), 16'h0001);
		temp = 16'h0300;
		wait_conv(1);
		chk(16'(alert_o), 16'h0000);
		wreg(2'h1, 16'h0380);
		chk(16'(asleep_o), 16'h0001);
		chk(16'(conv_run_o), 16'h0000);
		repeat (2) @(negedge clk_i);
		chk(16'(alert_o), 16'h0001);
		// Sleep and single conversions.
		n0 = n_conv;
		wreg(2'h3, 16'h0240);
		rreg(2'h3, v);
		chk(v, 16'h0240);
		repeat (300) @(negedge clk_i);
		chk(16'(n_conv - n0), 16'h0000);
		wreg(2'h1, 16'h8380);
		rreg(2'h1, v);
		chk(16'(v[15]), 16'h0001);
		wait_conv(1);
		rreg(2'h1, v);
		chk(16'(v[15]), 16'h0000);
		chk(16'(asleep_o), 16'h0001);
		wreg(2'h1, 16'h8380);
		wait_conv(1);
		repeat (300) @(negedge clk_i);
		chk(16'(n_conv - n0), 16'h0002);
		// General call reset, then wake.
		@(negedge clk_i) gc_reset_i = 1'b1;
		@(negedge clk_i) gc_reset_i = 1'b0;
		rreg(2'h1, v);
		chk(16'(v[9]), 16'h0000);
		wreg(2'h1, 16'h0080);
		wait_conv(2);
		chk(16'(n_conv - n0), 16'h0004);
		chk(16'(asleep_o), 16'h0000);
		test_done();
	end
endmodule : tb_tam_alert_ctl
